// [rtl/decode_pkg.sv]
// constants and types shared by the prefix and opcode field decoder
// Notes on behaviour
// - prefixes accepted in any order; the last segment override wins
// - 26h/2Eh/36h override segment to ES, CS, SS
// - 3Eh/64h/65h override segment to DS, FS, GS
// - 66h inverts default operand size
// - 67h inverts default address size
// - F0h asserts bus lock during execution
// - F2h/F3h repeat following string instruction
// - opcode one or two bytes; modrm refines group
// - opcode 80h is immediate group, modrm selects
// - register selector from opcode low bits or modrm
// - width bit: 0 byte, 1 word or dword
// - direction bit picks source and destination
// - sign-extend set: 8-bit immediate, extended
// - sign-extend clear: immediate equals operand size
// - bits 5:3 select special register in mov
// - control registers valid: 0, 2, 3, 4
// - debug 0-3,6,7 valid; test 3-7 valid
// - over 15 bytes raises protection fault, code 0
package decode_pkg;
  localparam logic [7:0] pfx_es = 8'h26; // extra segment override
  localparam logic [7:0] pfx_cs = 8'h2e; // code segment override
  localparam logic [7:0] pfx_ss = 8'h36; // stack segment override
  localparam logic [7:0] pfx_ds = 8'h3e; // data segment override
  localparam logic [7:0] pfx_fs = 8'h64; // f segment override
  localparam logic [7:0] pfx_gs = 8'h65; // g segment override
  localparam logic [7:0] pfx_opsize = 8'h66; // operand size inversion
  localparam logic [7:0] pfx_adsize = 8'h67; // address size inversion
  localparam logic [7:0] pfx_lock = 8'hf0; // bus lock
  localparam logic [7:0] repeat_while_unequal_prefix = 8'hf2; // repeat while not equal
  localparam logic [7:0] repeat_while_equal_prefix = 8'hf3; // repeat or repeat while equal
  localparam logic [7:0] escape_byte = 8'h0f; // two-byte opcode escape
  localparam logic [7:0] op_imm_group = 8'h80; // immediate group opcode
  localparam logic [7:0] op_mov_from_cr = 8'h20; // second byte, mov from control
  localparam logic [7:0] op_mov_from_dr = 8'h21; // second byte, mov from debug
  localparam logic [7:0] op_mov_to_cr = 8'h22; // second byte, mov to control
  localparam logic [7:0] op_mov_to_dr = 8'h23; // second byte, mov to debug
  localparam logic [7:0] op_mov_from_tr = 8'h24; // second byte, mov from test
  localparam logic [7:0] op_mov_to_tr = 8'h26; // second byte, mov to test
  localparam logic [7:0] ctrl_valid_mask = 8'h1d; // selectors 0,2,3,4
  localparam logic [7:0] dbg_valid_mask = 8'hcf; // selectors 0-3,6,7
  localparam logic [7:0] test_valid_mask = 8'hf8; // selectors 3-7
  localparam int max_insn_len = 15; // longest legal instruction in bytes
  localparam int w_bit = 0; // operand width bit position
  localparam int d_bit = 1; // direction bit position
  localparam int s_bit = 1; // sign-extend bit position
  localparam int sel_hi = 5; // selector field upper bit
  localparam int sel_lo = 3; // selector field lower bit
  localparam int sel_w = 3; // selector field width
  localparam logic [1:0] size_8 = 2'h0; // 8-bit code
  localparam logic [1:0] size_16 = 2'h1; // 16-bit code
  localparam logic [1:0] size_32 = 2'h2; // 32-bit code
  typedef enum logic [2:0] {
    seg_default = 3'h0,
    seg_es = 3'h1,
    seg_cs = 3'h2,
    seg_ss = 3'h3,
    seg_ds = 3'h4,
    seg_fs = 3'h5,
    seg_gs = 3'h6
  } seg_type;
  typedef enum logic [1:0] {
    sreg_none = 2'h0,
    sreg_ctrl = 2'h1,
    sreg_dbg = 2'h2,
    sreg_test = 2'h3
  } sreg_type;
  typedef enum logic [1:0] {
    st_prefix = 2'h0,
    st_second = 2'h1,
    st_modrm = 2'h2
  } state_type;
endpackage

// [rtl/prefix_classifier.sv]
// combinational classifier for one candidate prefix byte
`timescale 1ns/1ps
module prefix_classifier (
  input wire logic [7:0] byte_in, // byte under test
  output logic is_prefix, // byte is any prefix
  output decode_pkg::seg_type seg, // segment named, default if none
  output logic opsize, // operand size inversion
  output logic adsize, // address size inversion
  output logic lock, // bus lock prefix
  output logic rep_ne, // repeat while unequal
  output logic rep_e // repeat while equal
);
  import decode_pkg::*;
  // one flat compare per encoding
  always_comb begin
    seg = seg_default;
    unique case (byte_in)
      pfx_es: seg = seg_es;
      pfx_cs: seg = seg_cs;
      pfx_ss: seg = seg_ss;
      pfx_ds: seg = seg_ds;
      pfx_fs: seg = seg_fs;
      pfx_gs: seg = seg_gs;
      default: seg = seg_default;
    endcase
    opsize = (byte_in == pfx_opsize);
    adsize = (byte_in == pfx_adsize);
    lock = (byte_in == pfx_lock);
    rep_ne = (byte_in == repeat_while_unequal_prefix);
    rep_e = (byte_in == repeat_while_equal_prefix);
    is_prefix = (seg != seg_default) | opsize | adsize | lock | rep_ne | rep_e;
  end
endmodule

// [rtl/special_reg_check.sv]
// validity check of the special-register selector per register type
`timescale 1ns/1ps
module special_reg_check (
  input wire decode_pkg::sreg_type kind, // addressed register type
  input wire logic [2:0] sel, // selector bits
  output logic valid // selector legal for the type
);
  import decode_pkg::*;
  // masks hold one bit per legal selector value
  always_comb begin
    unique case (kind)
      sreg_ctrl: valid = ctrl_valid_mask[sel];
      sreg_dbg: valid = dbg_valid_mask[sel];
      sreg_test: valid = test_valid_mask[sel];
      sreg_none: valid = 1'b1;
    endcase
  end
endmodule

// [rtl/insn_front_decoder.sv]
// prefix and opcode field decoder between prefetch and execution
`timescale 1ns/1ps
module insn_front_decoder (
  input wire logic mclk, // core clock
  input wire logic sys_rst, // async reset, high
  input wire logic byte_valid, // prefetch offers a byte
  input wire logic [7:0] byte_data, // offered byte
  output logic byte_ready, // decoder takes the byte
  input wire logic default_32, // code segment default size is 32
  input wire logic exec_busy, // pipeline still executing last insn
  input wire logic exec_done, // pipeline retires the held insn
  input wire logic string_op, // held opcode is a string instruction
  input wire logic elem_left, // string elements remain
  output logic dec_valid, // decoded fields stand
  output logic [7:0] opcode, // last opcode byte
  output logic two_byte, // opcode had the escape
  output logic [7:0] modrm, // mod r/m byte
  output decode_pkg::seg_type seg_sel, // segment override
  output logic op32, // operand size is 32 (else 16)
  output logic addr32, // address size is 32
  output logic [1:0] opnd_size, // operand width code
  output logic [1:0] imm_size, // immediate field width code
  output logic imm_sext, // immediate sign-extended
  output logic reg_is_dest, // register selector is destination
  output logic [2:0] reg_sel, // general register selector
  output logic [2:0] group_op, // group operation from mod r/m
  output logic imm_group, // opcode is immediate group
  output decode_pkg::sreg_type sreg_kind, // special register type
  output logic [2:0] sreg_sel, // special register selector
  output logic bus_lock, // bus lock while executing
  output logic rep_ne, // repeat while unequal active
  output logic rep_e, // repeat while equal active
  output logic repeat_again, // string insn runs another element
  output logic invalid_op, // invalid opcode fault pulse
  output logic gp_fault, // protection fault pulse
  output logic [15:0] gp_err_code // fault error code
);
  import decode_pkg::*;
  // four bits reach the length limit before any wrap can hide an overflow
  localparam int len_w = 4; // length counter width
  localparam logic [len_w-1:0] len_limit = len_w'(max_insn_len); // most bytes allowed

  // instruction state; retire, fault or a bad selector clears the count, override, prefix and escape flags
  state_type state, next_state; // byte position in instruction
  logic [len_w-1:0] len, next_len; // bytes taken so far
  seg_type seg, next_seg; // accumulated override
  logic f_op, next_f_op; // operand size prefix seen
  logic f_ad, next_f_ad; // address size prefix seen
  logic f_lk, next_f_lk; // lock prefix seen
  logic f_rn, next_f_rn; // repeat while unequal seen
  logic f_re, next_f_re; // repeat while equal seen
  logic esc, next_esc; // escape byte seen
  logic [7:0] opc, next_opc; // opcode byte
  logic hold, next_hold; // decoded result held
  logic [7:0] out_modrm, next_out_modrm; // captured mod r/m
  logic lock_run, next_lock_run; // lock during execution
  logic inv, next_inv; // invalid opcode pulse
  logic gpf, next_gpf; // protection fault pulse

  // combinational helpers, meaningful in the cycle of a take; kind_now and need_modrm also while held
  logic c_pfx, c_op, c_ad, c_lk, c_rn, c_re; // classifier outs
  seg_type c_seg; // classifier segment
  logic sel_ok; // selector legal
  logic take; // byte taken this cycle
  logic need_modrm; // opcode carries mod r/m
  sreg_type kind_now; // special type of current opcode
  logic over_len; // byte would exceed the limit

  // the classifier sees the raw offered byte, so a prefix costs no extra cycle
  prefix_classifier u_pfx (
    .byte_in(byte_data),
    .is_prefix(c_pfx),
    .seg(c_seg),
    .opsize(c_op),
    .adsize(c_ad),
    .lock(c_lk),
    .rep_ne(c_rn),
    .rep_e(c_re)
  );

  // the special-register type follows from the two-byte opcode
  // any other escaped opcode is treated as an ordinary two-byte instruction
  always_comb begin
    kind_now = sreg_none;
    if (esc) begin
      unique case (opc)
        op_mov_from_cr, op_mov_to_cr: kind_now = sreg_ctrl;
        op_mov_from_dr, op_mov_to_dr: kind_now = sreg_dbg;
        op_mov_from_tr, op_mov_to_tr: kind_now = sreg_test;
        default: kind_now = sreg_none;
      endcase
    end
  end

  // the selector is judged on the byte in the mod r/m slot, before it is held,
  // so an illegal move never reaches the pipeline
  special_reg_check u_chk (
    .kind(kind_now),
    .sel(byte_data[sel_hi:sel_lo]),
    .valid(sel_ok)
  );

  // a new instruction waits until the last decode is consumed
  assign byte_ready = !hold;
  assign take = byte_valid && byte_ready;
  assign over_len = (len == len_limit);
  // limitation: displacement, s-i-b and immediate bytes are left to the pipeline
  // simplified: escaped special-register moves, 00-3f forms with bit 2 clear and 80-8f use mod r/m
  assign need_modrm = esc ? (kind_now != sreg_none) : (!opc[7] ? !opc[2] && !opc[6] : opc[7:4] == 4'h8);

  // byte walk: prefixes, optional escape byte, opcode, then the mod r/m slot byte
  always_comb begin
    next_state = state;
    next_len = len;
    next_seg = seg;
    next_f_op = f_op;
    next_f_ad = f_ad;
    next_f_lk = f_lk;
    next_f_rn = f_rn;
    next_f_re = f_re;
    next_esc = esc;
    next_opc = opc;
    next_hold = hold;
    next_out_modrm = out_modrm;
    next_inv = 1'b0;
    next_gpf = 1'b0;
    // retire clears the prefix state unless a string repeat keeps the decode
    if (hold && exec_done && !(string_op && (f_rn || f_re) && elem_left)) begin
      next_hold = 1'b0;
      next_len = '0;
      next_seg = seg_default;
      {next_f_op, next_f_ad, next_f_lk, next_f_rn, next_f_re, next_esc} = '0;
    end
    // the length check wins over decoding, so an overlong byte never decodes
    if (take) begin
      next_len = len + 1'b1;
      if (over_len) begin
        next_gpf = 1'b1;
        next_state = st_prefix;
        next_len = '0;
        next_seg = seg_default;
        {next_f_op, next_f_ad, next_f_lk, next_f_rn, next_f_re, next_esc} = '0;
      end else begin
        unique case (state)
          st_prefix: begin
            if (c_pfx) begin
              // flags only accumulate; the last segment override wins
              if (c_seg != seg_default) next_seg = c_seg;
              next_f_op = f_op | c_op;
              next_f_ad = f_ad | c_ad;
              next_f_lk = f_lk | c_lk;
              next_f_rn = f_rn | c_rn;
              next_f_re = f_re | c_re;
            end else if (byte_data == escape_byte) begin
              next_esc = 1'b1;
              next_state = st_second;
            end else begin
              next_opc = byte_data;
              next_state = st_modrm;
            end
          end
          st_second: begin
            next_opc = byte_data;
            next_state = st_modrm;
          end
          st_modrm: begin
            // opcode without mod r/m: this byte is still consumed and dropped
            next_out_modrm = need_modrm ? byte_data : 8'h00;
            next_inv = need_modrm && !sel_ok;
            next_hold = !(need_modrm && !sel_ok);
            next_state = st_prefix;
            if (need_modrm && !sel_ok) begin
              next_len = '0;
              next_seg = seg_default;
              {next_f_op, next_f_ad, next_f_lk, next_f_rn, next_f_re, next_esc} = '0;
            end
          end
          default: next_state = st_prefix;
        endcase
      end
    end
  end

  // bus lock spans the held instruction's execution
  // registered, so the lock pin cannot glitch while exec_busy settles
  always_comb begin
    next_lock_run = hold && f_lk && exec_busy;
  end

  // one register bank for all state; next values come from the processes above
  // reset loads constants only
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= st_prefix;
      len <= '0;
      seg <= seg_default;
      {f_op, f_ad, f_lk, f_rn, f_re, esc} <= '0;
      opc <= 8'h00;
      hold <= 1'b0;
      out_modrm <= 8'h00;
      lock_run <= 1'b0;
      inv <= 1'b0;
      gpf <= 1'b0;
    end else begin
      state <= next_state;
      len <= next_len;
      seg <= next_seg;
      {f_op, f_ad, f_lk, f_rn, f_re, esc} <= {next_f_op, next_f_ad, next_f_lk, next_f_rn, next_f_re, next_esc};
      opc <= next_opc;
      hold <= next_hold;
      out_modrm <= next_out_modrm;
      lock_run <= next_lock_run;
      inv <= next_inv;
      gpf <= next_gpf;
    end
  end

  // field extraction from held opcode and mod r/m
  // all fields derive from held registers, so they stand as long as dec_valid
  // op32, addr32, opnd_size and imm_size also follow default_32, which must not change mid-decode
  always_comb begin
    op32 = default_32 ^ f_op;
    addr32 = default_32 ^ f_ad;
    opnd_size = !opc[w_bit] ? size_8 : (op32 ? size_32 : size_16);
    imm_group = !esc && (opc[7:2] == op_imm_group[7:2]);
    imm_sext = imm_group && opc[s_bit];
    imm_size = imm_sext ? size_8 : opnd_size;
    reg_is_dest = opc[d_bit] && !imm_group;
    reg_sel = need_modrm ? out_modrm[sel_hi:sel_lo] : opc[2:0];
    group_op = out_modrm[sel_hi:sel_lo];
    sreg_kind = kind_now;
    sreg_sel = out_modrm[sel_hi:sel_lo];
  end

  // outputs come straight from registers, except the repeat_again pulse and the constant gp_err_code
  assign dec_valid = hold;
  assign opcode = opc;
  assign two_byte = esc;
  assign modrm = out_modrm;
  assign seg_sel = seg;
  assign bus_lock = lock_run;
  assign rep_ne = f_rn;
  assign rep_e = f_re;
  // a repeat answers exec_done without dropping the decode
  assign repeat_again = hold && exec_done && string_op && (f_rn || f_re) && elem_left;
  assign invalid_op = inv;
  assign gp_fault = gpf;
  assign gp_err_code = 16'h0000;

  // checks; pulses stand one cycle, one edge after the offending byte
  // the selector checks skip an overlong byte, where the length fault wins
  a_len_fault: assert property (@(posedge mclk) disable iff (sys_rst)
    (take && len == len_limit) |=> gp_fault && gp_err_code == 16'h0000)
    else $error("length overflow did not fault");
  a_ctrl_sel: assert property (@(posedge mclk) disable iff (sys_rst)
    (take && !over_len && state == st_modrm && kind_now == sreg_ctrl && byte_data[sel_hi:sel_lo] == 3'h1)
    |=> invalid_op)
    else $error("bad control selector accepted");
  a_test_sel: assert property (@(posedge mclk) disable iff (sys_rst)
    (take && !over_len && state == st_modrm && kind_now == sreg_test && byte_data[sel_hi:sel_lo] < 3'h3)
    |=> invalid_op && !dec_valid)
    else $error("bad test selector accepted");
  a_lock_exec: assert property (@(posedge mclk) disable iff (sys_rst)
    (hold && f_lk && exec_busy) |=> bus_lock)
    else $error("lock not driven during execution");
  a_op_size: assert property (@(posedge mclk) disable iff (sys_rst)
    (dec_valid && opc[w_bit] && f_op && !default_32) |-> opnd_size == size_32)
    else $error("operand size not inverted");
  a_addr_size: assert property (@(posedge mclk) disable iff (sys_rst)
    dec_valid |-> addr32 == (default_32 != f_ad))
    else $error("address size wrong");
  a_sext_imm: assert property (@(posedge mclk) disable iff (sys_rst)
    (dec_valid && imm_group && opc[s_bit]) |-> imm_size == size_8 && imm_sext)
    else $error("sign-extended immediate not 8 bits");
  a_imm_width: assert property (@(posedge mclk) disable iff (sys_rst)
    (dec_valid && !imm_sext) |-> imm_size == opnd_size)
    else $error("immediate width differs from operand size");
  a_seg_keep: assert property (@(posedge mclk) disable iff (sys_rst)
    (take && state == st_prefix && byte_data == pfx_cs && !over_len) |=> seg_sel == seg_cs)
    else $error("code segment override lost");
  a_repeat_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    repeat_again |=> dec_valid && $stable(opcode))
    else $error("repeat dropped instruction");
  // selector, length, lock and register source checks
  a_dbg_sel: assert property (@(posedge mclk) disable iff (sys_rst)
    (take && !over_len && state == st_modrm && kind_now == sreg_dbg && byte_data[sel_hi:sel_lo] inside {3'h4, 3'h5})
    |=> invalid_op && !dec_valid)
    else $error("bad debug selector accepted");
  a_ctrl_ok: assert property (@(posedge mclk) disable iff (sys_rst)
    (take && !over_len && state == st_modrm && kind_now == sreg_ctrl && byte_data[sel_hi:sel_lo] == 3'h4)
    |=> dec_valid && !invalid_op)
    else $error("good control selector refused");
  a_len_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
    (take && !over_len) |=> !gp_fault)
    else $error("fault without length overflow");
  a_lock_idle: assert property (@(posedge mclk) disable iff (sys_rst)
    !hold |=> !bus_lock)
    else $error("lock outside execution");
  a_modrm_reg: assert property (@(posedge mclk) disable iff (sys_rst)
    (take && !over_len && state == st_modrm && need_modrm && sel_ok)
    |=> reg_sel == $past(byte_data[sel_hi:sel_lo]))
    else $error("register selector not from mod r/m");
  // main scenarios the bench must reach
  c_prefixed: cover property (@(posedge mclk) disable iff (sys_rst) dec_valid && f_op && f_lk);
  c_two_byte: cover property (@(posedge mclk) disable iff (sys_rst) dec_valid && esc);
  c_fault: cover property (@(posedge mclk) disable iff (sys_rst) gp_fault);
  c_invalid: cover property (@(posedge mclk) disable iff (sys_rst) invalid_op);
  c_repeat: cover property (@(posedge mclk) disable iff (sys_rst) repeat_again);
endmodule

// [test/prefetch_model.sv]
// prefetch-side model that offers instruction bytes to the decoder
`timescale 1ns/1ps
module prefetch_model (
  input wire logic mclk, // core clock
  input wire logic sys_rst, // async reset, high
  input wire logic byte_ready, // decoder takes the byte
  output logic byte_valid, // byte offered
  output logic [7:0] byte_data // offered byte
);
  logic [7:0] q[$]; // bytes still to send
  int stall = 0; // idle cycles before each byte, slow mode
  initial begin
    byte_valid = 1'b0;
    byte_data = 8'h5a;
  end
  // offer one byte at a time, hold it until taken at a rising edge
  always begin
    @(posedge mclk);
    while (!sys_rst && q.size() != 0) begin
      repeat (stall) @(posedge mclk);
      #1;
      byte_data = q.pop_front();
      byte_valid = 1'b1;
      do @(posedge mclk); while (byte_ready !== 1'b1);
      // back to back bytes keep valid up; otherwise release the line
      if (stall != 0 || q.size() == 0) begin
        #1;
        byte_valid = 1'b0;
        // released line flips so stale data never passes for a byte
        byte_data = ~byte_data;
      end
    end
  end
endmodule

// [test/testbench.sv]
// self-checking bench for the prefix and opcode field decoder
`timescale 1ns/1ps
module testbench;
  import decode_pkg::*;
  logic mclk = 1'b0, sys_rst = 1'b1; // clock, reset
  logic default_32 = 1'b0, exec_busy = 1'b0, exec_done = 1'b0; // pipeline side
  logic string_op = 1'b0, elem_left = 1'b0; // string status
  logic byte_valid, byte_ready, dec_valid, two_byte, op32, addr32, imm_sext, reg_is_dest; // handshake, flags
  logic imm_group, bus_lock, rep_ne, rep_e, repeat_again, invalid_op, gp_fault; // flags
  logic [7:0] byte_data, opcode, modrm; // bytes
  logic [1:0] opnd_size, imm_size; // size codes
  logic [2:0] reg_sel, group_op, sreg_sel; // selectors
  logic [15:0] gp_err_code; // fault code
  seg_type seg_sel; // segment override
  sreg_type sreg_kind; // special register type
  int err_total = 0, compares = 0; // counters
  int n_inv = 0, n_gp = 0, n_rep = 0; // pulse counts
  logic [15:0] lfsr = 16'h0027; // seed 39, fixed for repeatable runs
  logic [7:0] seg_pfx [6] = '{8'h26, 8'h2e, 8'h36, 8'h3e, 8'h64, 8'h65}; // es..gs
  logic [7:0] misc_pfx [4] = '{8'h66, 8'h67, 8'hf2, 8'hf3}; // size, repeat
  logic [7:0] ops [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h80, 8'h81, 8'h83}; // modrm users
  logic [7:0] sops [6] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h26}; // special moves
  sreg_type kinds [6] = '{sreg_ctrl, sreg_dbg, sreg_ctrl, sreg_dbg, sreg_test, sreg_test}; // their types

  // core clock, 4 ns period
  always #2 mclk = ~mclk;

  insn_front_decoder DUT (.mclk, .sys_rst, .byte_valid, .byte_data, .byte_ready, .default_32, .exec_busy,
    .exec_done, .string_op, .elem_left, .dec_valid, .opcode, .two_byte, .modrm, .seg_sel, .op32, .addr32,
    .opnd_size, .imm_size, .imm_sext, .reg_is_dest, .reg_sel, .group_op, .imm_group, .sreg_kind, .sreg_sel,
    .bus_lock, .rep_ne, .rep_e, .repeat_again, .invalid_op, .gp_fault, .gp_err_code);
  prefetch_model feeder (.mclk, .sys_rst, .byte_ready, .byte_valid, .byte_data);

  // next pseudo-random byte from the shift register
  function logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction
  // operand width code from w bit and data size
  function automatic logic [1:0] size_of(input logic w, input logic wide);
    return w ? (wide ? size_32 : size_16) : size_8;
  endfunction
  // legal selectors per special register type
  function automatic logic sel_ok(input sreg_type kind, input logic [2:0] sel);
    case (kind)
      sreg_ctrl: return sel inside {3'h0, 3'h2, 3'h3, 3'h4};
      sreg_dbg: return sel inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
      default: return sel >= 3'h3;
    endcase
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic feed(input logic [7:0] b[$]);
    foreach (b[i]) feeder.q.push_back(b[i]);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // bounded wait for a decode to stand
  task automatic wait_dec(output bit got);
    got = 0;
    for (int i = 0; i < 80 && !got; i++) begin
      @(posedge mclk);
      #1;
      got = (dec_valid === 1'b1);
    end
    chk("dec_valid", 1, got);
  endtask
  // one-cycle retire pulse from the pipeline
  task automatic retire();
    @(posedge mclk);
    #1 exec_done = 1'b1;
    @(posedge mclk);
    #1 exec_done = 1'b0;
    exec_busy = 1'b0;
  endtask

  // pulses stand one cycle only, so count them at every edge
  always @(posedge mclk) begin
    if (invalid_op === 1'b1) n_inv++;
    if (repeat_again === 1'b1) n_rep++;
    if (gp_fault === 1'b1) begin
      n_gp++;
      chk("gp_err_code", 0, gp_err_code);
    end
  end

  // send prefixes, opcode, mod r/m and compare the prefix, opcode and operand fields
  task automatic run_plain(input logic [7:0] pf[$], input logic [7:0] opc, input logic [7:0] mrm, input logic [2:0] seg);
    bit got;
    logic wide;
    feed(pf);
    feed({opc, mrm});
    wait_dec(got);
    wide = default_32 ^ (8'h66 inside {pf});
    chk("seg_sel", seg, seg_sel);
    chk("op32", wide, op32);
    chk("addr32", default_32 ^ (8'h67 inside {pf}), addr32);
    chk("rep_ne", 8'hf2 inside {pf}, rep_ne);
    chk("rep_e", 8'hf3 inside {pf}, rep_e);
    chk("opcode", opc, opcode);
    chk("modrm", mrm, modrm);
    chk("two_byte", 0, two_byte);
    chk("opnd_size", size_of(opc[0], wide), opnd_size);
    chk("imm_group", opc[7], imm_group);
    if (opc[7]) begin
      chk("group_op", mrm[5:3], group_op);
      chk("imm_sext", opc[1], imm_sext);
      chk("imm_size", opc[1] ? size_8 : size_of(opc[0], wide), imm_size);
    end else begin
      chk("reg_is_dest", opc[1], reg_is_dest);
      chk("reg_sel", mrm[5:3], reg_sel);
    end
    retire();
    chk("dec_valid", 0, dec_valid);
  endtask

  // watchdog, far beyond the expected run length
  initial begin
    #100000;
    err_total++;
    give_verdict();
  end

  initial begin
    logic [7:0] pf[$];
    logic [7:0] opc, r;
    logic [2:0] seg;
    bit got;
    int nb;
    repeat (8) @(posedge mclk);
    chk("byte_ready", 1, byte_ready);
    chk("dec_valid", 0, dec_valid);
    #1 sys_rst = 1'b0;
    // random prefix mixes, each also sent in reversed order
    for (int k = 0; k < 30; k++) begin
      pf = {};
      default_32 = rnd() > 8'h7f;
      feeder.stall = (k % 3 == 0) ? 3 : 0;
      nb = rnd() % 5;
      repeat (nb) pf.push_back(misc_pfx[rnd() % 4]);
      seg = 3'(rnd() % 7);
      if (seg != 3'h0) pf.insert(rnd() % (pf.size() + 1), seg_pfx[seg - 3'h1]);
      opc = ops[rnd() % 7];
      r = rnd();
      run_plain(pf, opc, r, seg);
      pf.reverse();
      run_plain(pf, opc, r, seg);
    end
    feeder.stall = 0;
    // longest legal instruction, then one byte too long
    pf = {};
    repeat (13) pf.push_back(8'h66);
    run_plain(pf, 8'h01, 8'hc3, 3'h0);
    chk("gp_fault count", 0, n_gp);
    repeat (16) feeder.q.push_back(8'h67);
    settle(30);
    chk("gp_fault count", 1, n_gp);
    chk("dec_valid", 0, dec_valid);
    // every selector on every special move kind
    foreach (sops[i]) for (int s = 0; s < 8; s++) begin
      nb = n_inv;
      r = {2'b11, 3'(s), 3'h0};
      feed({8'h0f, sops[i], r});
      if (sel_ok(kinds[i], 3'(s))) begin
        wait_dec(got);
        chk("sreg_kind", kinds[i], sreg_kind);
        chk("sreg_sel", s, sreg_sel);
        chk("two_byte", 1, two_byte);
        retire();
      end else begin
        settle(8);
      end
      chk("invalid_op count", nb + !sel_ok(kinds[i], 3'(s)), n_inv);
    end
    // bus lock only while the locked instruction executes
    feed({8'hf0, 8'h00, 8'hc0});
    wait_dec(got);
    chk("bus_lock", 0, bus_lock);
    exec_busy = 1'b1;
    settle(3);
    chk("bus_lock", 1, bus_lock);
    retire();
    settle(2);
    chk("bus_lock", 0, bus_lock);
    // both repeat prefixes: decode kept while elements remain
    for (int i = 2; i < 4; i++) begin
      feed({misc_pfx[i], 8'ha4, 8'h00});
      wait_dec(got);
      chk("reg_sel", 3'h4, reg_sel);
      chk("modrm", 0, modrm);
      string_op = 1'b1;
      elem_left = 1'b1;
      nb = n_rep;
      retire();
      settle(1);
      chk("repeat_again count", nb + 1, n_rep);
      chk("dec_valid", 1, dec_valid);
      elem_left = 1'b0;
      retire();
      chk("dec_valid", 0, dec_valid);
      string_op = 1'b0;
    end
    give_verdict();
  end
endmodule
